// [hdl/deb_bus_ctrl.sv]
// External bus control: strobes, port lines, reset, interrupt, poll, clock.
// Assumes one cmd per machine cycle and pins asynchronous to ref_clk.
//
// What this block does
// (R1) Poll-branch jumps to target when poll pin low.
// (R2) Input strobe low only in input first cycle.
// (R3) Input strobe active keeps fetch, output strobes high.
// (R4) Fetch strobe low every cycle except data strobes.
// (R5) Fetch strobe asserts for on-chip and off-chip fetches.
// (R6) Output strobe only output first, table-store second.
// (R7) Output strobe active keeps fetch, input strobes high.
// (R8) Falling edge or low level sets pending latch.
// (R9) Reset held five cycles; strobes high, bus released.
// (R10) Counter and address cleared one cycle after reset.
// (R11) Reset disables interrupts, keeps overflow mode.
// (R12) Map select chooses on-chip or all-external program.
// (R13) Clock output is quarter rate, half duty.
// (R14) Data bus driven only when outputting, port0/1, or host read strobe low.
// (R15) Port lines carry port or counter low bits.
// (R16) Host read strobe drives latch onto bus.
// (R17) Host write strobe rising edge captures data.
// (R18) Both mode pins tied alike by the board.
// (R19) Coprocessor mode ignores poll and interrupt pins.
// (R20) Flag pin follows control bit ten directly.
// (R21) Reset floats serial outputs; edge sets control flag.
// (R22) Coprocessor mode port lines carry latch flags.
// (R23) Outside reset, strobes, address and port lines change on machine cycle boundaries.
`timescale 1ns/1ps
module deb_bus_ctrl #(
    parameter int unsigned ONCHIP_WORDS = deb_pkg::ONCHIP_WORDS_STD
) (
    // Clock and reset.
    input  wire logic                  ref_clk,
    input  wire logic                  arst_n,
    // Wishbone slave.
    input  wire deb_pkg::deb_wb_req_s  wb_req,
    output logic                       wb_ack,
    output logic [31:0]                wb_dat_r,
    // Core side.
    input  wire deb_pkg::deb_cmd_s     cmd,
    input  wire logic                  irq_grant,
    output logic                       cycle_tick,
    output logic [deb_pkg::ADDR_W-1:0] prog_counter,
    output logic                       irq_request,
    output logic                       fetch_external,
    output logic [15:0]                core_rdata,
    // Pins.
    input  wire logic                  reset_in_n,
    input  wire logic                  branch_poll_input,
    input  wire logic                  ext_irq_alt_n,
    input  wire logic                  memory_map_select,
    input  wire logic                  host_mode_select,
    input  wire logic                  coproc_rd_n,
    input  wire logic                  coproc_wr_n,
    input  wire logic                  latch_byte_select,
    input  wire logic [15:0]           data_in,
    output logic [15:0]                data_out,
    output logic                       data_oe,
    output logic [deb_pkg::ADDR_W-1:0] prog_addr,
    output logic [2:0]                 port_select_lines,
    output logic [2:0]                 port_select_oe,
    output logic                       program_fetch_strobe_n,
    output logic                       input_data_strobe_n,
    output logic                       output_data_strobe_n,
    output logic                       divided_clock_out,
    output logic                       user_flag_output,
    output logic                       serial_out_oe
);
    import deb_pkg::*;

    // Chooses the data-strobe state a cycle kind asks for.
    function automatic logic is_data_cycle(input deb_op_e op);
        return (op == DEB_OP_IN) || (op == DEB_OP_OUT) || (op == DEB_OP_TBLW2);
    endfunction : is_data_cycle

    // Three-stage pin synchronisers; a value counts once stages two and three agree.
    logic [PIN_COUNT-1:0] pin_raw;
    logic [PIN_COUNT-1:0] sync1_ff;
    logic [PIN_COUNT-1:0] sync2_ff;
    logic [PIN_COUNT-1:0] sync3_ff;
    logic [PIN_COUNT-1:0] pin_ff;
    logic [PIN_COUNT-1:0] pin_prev_ff;

    assign pin_raw = {latch_byte_select, coproc_wr_n, coproc_rd_n, host_mode_select,
                      memory_map_select, ext_irq_alt_n, branch_poll_input, reset_in_n};

    genvar gi;
    generate
        for (gi = 0; gi < PIN_COUNT; gi++)
        begin : g_sync
            // Idle levels are high so no false edge appears out of reset.
            always_ff @(posedge ref_clk or negedge arst_n)
            begin
                if (!arst_n)
                begin
                    sync1_ff[gi]    <= 1'b1;
                    sync2_ff[gi]    <= 1'b1;
                    sync3_ff[gi]    <= 1'b1;
                    pin_ff[gi]      <= 1'b1;
                    pin_prev_ff[gi] <= 1'b1;
                end
                else
                begin
                    sync1_ff[gi]    <= pin_raw[gi];
                    sync2_ff[gi]    <= sync1_ff[gi];
                    sync3_ff[gi]    <= sync2_ff[gi];
                    pin_prev_ff[gi] <= pin_ff[gi];
                    if (sync2_ff[gi] == sync3_ff[gi])
                    begin
                        pin_ff[gi] <= sync3_ff[gi];
                    end
                end
            end
        end
    endgenerate

    logic host_mode;
    logic irq_fall;
    logic wr_rise;
    logic rd_rise;
    logic        tx_full_ff;
    logic        rx_empty_ff;
    logic [15:0] ctrl_ff;
    assign host_mode = !pin_ff[PIN_HOST];                               // R18
    assign irq_fall  = pin_prev_ff[PIN_IRQ] && !pin_ff[PIN_IRQ] && !host_mode;    // R19
    assign wr_rise   = !pin_prev_ff[PIN_WR] && pin_ff[PIN_WR] && host_mode;
    assign rd_rise   = !pin_prev_ff[PIN_RD] && pin_ff[PIN_RD] && host_mode;

    // Machine cycle phase counter and the quarter-rate clock output.
    logic [1:0] phase_ff;
    logic       boundary;
    assign boundary = (phase_ff == 2'(CLK_DIV - 1));

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            phase_ff          <= 2'b00;
            divided_clock_out <= 1'b1;
            cycle_tick        <= 1'b0;
        end
        else
        begin
            phase_ff          <= phase_ff + 2'b01;
            divided_clock_out <= (phase_ff == 2'(CLK_DIV - 1)) || (phase_ff == 2'b00);  // R13
            cycle_tick        <= boundary;
        end
    end

    // Reset sequencing: the pin counts after five low clocks, then the
    // counter clears at the next boundary.
    deb_rst_e   rst_state_ff;
    logic [2:0] rst_low_cnt_ff;
    logic       in_reset;
    assign in_reset = (rst_state_ff != DEB_RUN);

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rst_state_ff   <= DEB_HELD;
            rst_low_cnt_ff <= 3'd0;
        end
        else
        begin
            if (pin_ff[PIN_RESET])
            begin
                rst_low_cnt_ff <= 3'd0;
            end
            else if (rst_low_cnt_ff != 3'(RST_HOLD_CYC))
            begin
                rst_low_cnt_ff <= rst_low_cnt_ff + 3'd1;
            end
            unique case (rst_state_ff)
                DEB_RUN:
                begin
                    if (rst_low_cnt_ff == 3'(RST_HOLD_CYC))              // R9
                    begin
                        rst_state_ff <= DEB_CLEAR;
                    end
                end
                DEB_CLEAR:
                begin
                    if (boundary)                                        // R10
                    begin
                        rst_state_ff <= DEB_HELD;
                    end
                end
                DEB_HELD:
                begin
                    if (pin_ff[PIN_RESET] && boundary)
                    begin
                        rst_state_ff <= DEB_RUN;
                    end
                end
                default:
                begin
                    rst_state_ff <= DEB_HELD;
                end
            endcase
        end
    end

    // Program counter. Only fetch cycles advance it; data cycles hold it.
    logic [ADDR_W-1:0] nxt_pc;
    always_comb
    begin
        nxt_pc = prog_counter;
        if (cmd.op == DEB_OP_POLL_BRANCH_INSTRUCTION && !pin_ff[PIN_POLL] && !host_mode)  // R1 R19
        begin
            nxt_pc = cmd.target;
        end
        else if (!is_data_cycle(cmd.op))
        begin
            nxt_pc = prog_counter + 12'h001;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            prog_counter <= 12'h000;
        end
        else if (rst_state_ff == DEB_HELD || (rst_state_ff == DEB_CLEAR && boundary))
        begin
            prog_counter <= 12'h000;                                    // R10
        end
        else if (rst_state_ff == DEB_RUN && boundary)
        begin
            prog_counter <= nxt_pc;
        end
    end

    // Outside reset, strobes, address and port lines change only at the cycle boundary.
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            program_fetch_strobe_n <= 1'b1;
            input_data_strobe_n    <= 1'b1;
            output_data_strobe_n   <= 1'b1;
            prog_addr              <= 12'h000;
            port_select_lines      <= 3'b000;
            fetch_external         <= 1'b1;
        end
        else if (in_reset)
        begin
            program_fetch_strobe_n <= 1'b1;                             // R9
            input_data_strobe_n    <= 1'b1;
            output_data_strobe_n   <= 1'b1;
            if (rst_state_ff == DEB_HELD || boundary)
            begin
                prog_addr         <= 12'h000;                           // R10
                port_select_lines <= 3'b000;
            end
        end
        else if (boundary)                                              // R23
        begin
            // Exactly one strobe is low per machine cycle.
            program_fetch_strobe_n <= is_data_cycle(cmd.op);            // R4 R5 R3 R7
            input_data_strobe_n    <= (cmd.op != DEB_OP_IN);            // R2
            output_data_strobe_n   <= !(cmd.op == DEB_OP_OUT ||
                                        cmd.op == DEB_OP_TBLW2);        // R6
            prog_addr              <= nxt_pc;
            fetch_external         <= !pin_ff[PIN_MAP] ||
                                      (32'(nxt_pc) >= ONCHIP_WORDS);    // R12
            if (host_mode)
            begin
                port_select_lines <= {tx_full_ff, rx_empty_ff, 1'b0};   // R22
            end
            else if (cmd.op == DEB_OP_IN || cmd.op == DEB_OP_OUT)
            begin
                port_select_lines <= cmd.port;                          // R15
            end
            else
            begin
                port_select_lines <= nxt_pc[2:0];                       // R15
            end
        end
    end

    // Pin enables. In coprocessor mode the lowest port line is the host's
    // byte select input, so it is released; serial outputs float in reset.
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            port_select_oe <= 3'b111;
            serial_out_oe  <= 1'b0;
        end
        else
        begin
            port_select_oe <= {2'b11, !host_mode};                      // R22
            serial_out_oe  <= !in_reset;                                // R21
        end
    end

    // Coprocessor latches and their flags.
    logic [15:0] tx_latch_ff;
    logic [15:0] rx_latch_ff;
    logic        wb_tx_wr;
    logic        wb_rx_rd;

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            tx_full_ff  <= 1'b0;
            rx_empty_ff <= 1'b1;
            tx_latch_ff <= 16'h0000;
            rx_latch_ff <= 16'h0000;
        end
        else
        begin
            if (wb_tx_wr)
            begin
                tx_latch_ff <= wb_req.dat[15:0];
            end
            // A load in the same cycle as the host's read end wins.
            tx_full_ff <= wb_tx_wr || (tx_full_ff && !rd_rise);         // R16
            if (wr_rise)
            begin
                rx_latch_ff <= data_in;                                 // R17
            end
            rx_empty_ff <= !wr_rise && (rx_empty_ff || wb_rx_rd);       // R17
        end
    end

    // Data bus drive: off in reset, on for output, port 0/1 input, host reads.
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            data_out   <= 16'h0000;
            data_oe    <= 1'b0;
            core_rdata <= 16'h0000;
        end
        else if (in_reset)
        begin
            data_oe <= 1'b0;                                            // R9
        end
        else if (host_mode)
        begin
            data_out <= tx_latch_ff;
            data_oe  <= !pin_ff[PIN_RD];                                // R16
        end
        else if (boundary)
        begin
            data_out <= cmd.wdata;
            data_oe  <= cmd.op == DEB_OP_OUT || cmd.op == DEB_OP_TBLW2 ||
                        (cmd.op == DEB_OP_IN && cmd.port[2:1] == 2'b00);  // R14
        end
        else if (!input_data_strobe_n && phase_ff == 2'(CLK_DIV - 2))
        begin
            core_rdata <= data_in;
        end
    end

    // Interrupt capture: edge or low level sets pending; an event beats a grant.
    logic irq_pend_ff;
    logic irq_event;
    assign irq_event = (irq_fall || !pin_ff[PIN_IRQ]) && !host_mode;    // R8 R19

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            irq_pend_ff <= 1'b0;
            irq_request <= 1'b0;
        end
        else if (in_reset)
        begin
            irq_pend_ff <= 1'b0;                                        // R11
            irq_request <= 1'b0;
        end
        else
        begin
            irq_pend_ff <= irq_event || (irq_pend_ff && !irq_grant);    // R8
            irq_request <= irq_pend_ff && ctrl_ff[CTL_IRQ_EN] && !irq_grant;
        end
    end

    // Control register and flag pin. Overflow mode survives the reset pin.
    logic        wb_ctrl_wr;

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ctrl_ff          <= CTRL_RESET;
            user_flag_output <= 1'b0;
        end
        else
        begin
            if (wb_ctrl_wr)
            begin
                ctrl_ff[CTL_FLAG_OUT] <= wb_req.dat[CTL_FLAG_OUT];      // R20
                ctrl_ff[CTL_IRQ_EN]   <= wb_req.dat[CTL_IRQ_EN];
                ctrl_ff[CTL_OVF_MODE] <= wb_req.dat[CTL_OVF_MODE];
            end
            if (in_reset)
            begin
                ctrl_ff[CTL_IRQ_EN] <= 1'b0;                            // R11
            end
            // Edge flag: write one clears, but a new edge wins.
            ctrl_ff[CTL_EXT_IRQ_FLAG] <= irq_fall ||                    // R21
                (ctrl_ff[CTL_EXT_IRQ_FLAG] &&
                 !(wb_ctrl_wr && wb_req.dat[CTL_EXT_IRQ_FLAG]) && !in_reset);
            user_flag_output <= ctrl_ff[CTL_FLAG_OUT];                  // R20
        end
    end

    // Wishbone slave: ack one cycle after the request; unmapped reads are zero.
    logic wb_take;
    assign wb_take    = wb_req.cyc && wb_req.stb && !wb_ack;
    assign wb_ctrl_wr = wb_take && wb_req.we && wb_req.adr == OFS_CTRL && wb_req.sel[1];
    assign wb_tx_wr   = wb_take && wb_req.we && wb_req.adr == OFS_TXLAT && wb_req.sel[0];
    assign wb_rx_rd   = wb_take && !wb_req.we && wb_req.adr == OFS_RXLAT;

    logic [31:0] nxt_rdata;
    always_comb
    begin
        nxt_rdata = 32'h0000_0000;
        unique case (wb_req.adr)
            OFS_CTRL:   nxt_rdata = {16'h0000, ctrl_ff};
            OFS_STATUS:
            begin
                nxt_rdata[ST_IRQ_PEND]  = irq_pend_ff;
                nxt_rdata[ST_POLL]      = pin_ff[PIN_POLL];
                nxt_rdata[ST_MAP_SEL]   = pin_ff[PIN_MAP];
                nxt_rdata[ST_HOST_MODE] = host_mode;
                nxt_rdata[ST_TX_FULL]   = tx_full_ff;
                nxt_rdata[ST_RX_EMPTY]  = rx_empty_ff;
                nxt_rdata[ST_BYTE_SEL]  = pin_ff[PIN_BSEL];
                nxt_rdata[ST_IN_RESET]  = in_reset;
                nxt_rdata[ST_PC_LSB +: ADDR_W] = prog_counter;
            end
            OFS_TXLAT:  nxt_rdata = {16'h0000, tx_latch_ff};
            OFS_RXLAT:  nxt_rdata = {16'h0000, rx_latch_ff};
            default:    nxt_rdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            wb_ack   <= 1'b0;
            wb_dat_r <= 32'h0000_0000;
        end
        else
        begin
            wb_ack   <= wb_take;
            wb_dat_r <= wb_take && !wb_req.we ? nxt_rdata : 32'h0000_0000;
        end
    end

endmodule : deb_bus_ctrl

// [hdl/deb_pkg.sv]
// Package of the external bus control block: map, fields, counts, carriers.
// Assumes ref_clk stands for the oscillator input.
package deb_pkg;

    // Clock and machine cycle timing.
    localparam int unsigned CLK_DIV          = 4;
    localparam int unsigned RST_HOLD_CYC     = 5;

    // Program memory map.
    localparam int unsigned ADDR_W           = 12;
    localparam int unsigned ONCHIP_WORDS_STD = 1536;
    localparam int unsigned ONCHIP_WORDS_BIG = 4096;

    // Register byte offsets.
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_TXLAT  = 8'h08;
    localparam logic [7:0] OFS_RXLAT  = 8'h0C;

    // Control register fields.
    localparam int unsigned CTL_EXT_IRQ_FLAG = 0;
    localparam int unsigned CTL_IRQ_EN       = 1;
    localparam int unsigned CTL_OVF_MODE     = 2;
    localparam int unsigned CTL_FLAG_OUT     = 10;
    localparam logic [15:0] CTRL_RESET       = 16'h0000;

    // Status register fields.
    localparam int unsigned ST_IRQ_PEND  = 0;
    localparam int unsigned ST_POLL      = 1;
    localparam int unsigned ST_MAP_SEL   = 2;
    localparam int unsigned ST_HOST_MODE = 3;
    localparam int unsigned ST_TX_FULL   = 4;
    localparam int unsigned ST_RX_EMPTY  = 5;
    localparam int unsigned ST_BYTE_SEL  = 6;
    localparam int unsigned ST_IN_RESET  = 7;
    localparam int unsigned ST_PC_LSB    = 16;

    // Synchronised pin indices.
    localparam int unsigned PIN_RESET = 0;
    localparam int unsigned PIN_POLL  = 1;
    localparam int unsigned PIN_IRQ   = 2;
    localparam int unsigned PIN_MAP   = 3;
    localparam int unsigned PIN_HOST  = 4;
    localparam int unsigned PIN_RD    = 5;
    localparam int unsigned PIN_WR    = 6;
    localparam int unsigned PIN_BSEL  = 7;
    localparam int unsigned PIN_COUNT = 8;

    // Machine cycle kind presented by the execution core.
    typedef enum logic [2:0] {
        DEB_OP_FETCH = 3'b000,
        DEB_OP_POLL_BRANCH_INSTRUCTION  = 3'b001,
        DEB_OP_IN    = 3'b011,
        DEB_OP_OUT   = 3'b010,
        DEB_OP_TBLW2 = 3'b110
    } deb_op_e;

    // Reset sequencing RUN, CLEAR, HELD; Gray coded except the RUN to CLEAR step.
    typedef enum logic [1:0] {
        DEB_RUN   = 2'b00,
        DEB_HELD  = 2'b01,
        DEB_CLEAR = 2'b11
    } deb_rst_e;

    // One machine cycle request from the core.
    typedef struct packed {
        deb_op_e           op;
        logic [2:0]        port;
        logic [ADDR_W-1:0] target;
        logic [15:0]       wdata;
    } deb_cmd_s;

    // Classic Wishbone request.
    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [7:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } deb_wb_req_s;

endpackage : deb_pkg

// [sim/deb_bus_ctrl_assertions.sv]
// Checker of strobe exclusion, machine cycle framing and the clock output.
// Assumes a bind to deb_bus_ctrl and ref_clk as its only clock.
`timescale 1ns/1ps
module deb_bus_ctrl_assertions (
    // Clock and reset.
    input wire logic        ref_clk,
    input wire logic        arst_n,
    // Watched ports.
    input wire logic        cycle_tick,
    input wire logic        host_mode_select,
    input wire logic        serial_out_oe,
    input wire logic        data_oe,
    input wire logic [11:0] prog_addr,
    input wire logic [2:0]  port_select_lines,
    input wire logic        program_fetch_strobe_n,
    input wire logic        input_data_strobe_n,
    input wire logic        output_data_strobe_n,
    input wire logic        divided_clock_out
);
    // One domain, so the async reset masks every check.
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);
    // Two cycles high then two low make a quarter-rate clock.
    sequence s_hi2; divided_clock_out ##1 divided_clock_out; endsequence
    sequence s_lo2; !divided_clock_out ##1 !divided_clock_out; endsequence
    a_clk_quarter: assert property ($rose(divided_clock_out) |-> s_hi2 ##1 s_lo2)
        else $error("clock out not quarter rate");
    a_in_excl: assert property (!input_data_strobe_n |-> program_fetch_strobe_n
        && output_data_strobe_n) else $error("input strobe overlaps");
    a_out_excl: assert property (!output_data_strobe_n |-> program_fetch_strobe_n
        && input_data_strobe_n) else $error("output strobe overlaps");
    a_in_start: assert property ($fell(input_data_strobe_n) |-> cycle_tick)
        else $error("input strobe off cycle start");
    a_out_whole: assert property ($fell(output_data_strobe_n) |-> cycle_tick
        ##1 !output_data_strobe_n [*3]) else $error("output strobe not one cycle");
    a_tick_gap: assert property (cycle_tick |=> !cycle_tick [*3] ##1 cycle_tick)
        else $error("machine cycle not four clocks");
    // Out of reset and in normal mode a cycle without data strobe must fetch.
    a_fetch_else: assert property (cycle_tick && serial_out_oe && host_mode_select
        && input_data_strobe_n && output_data_strobe_n |-> !program_fetch_strobe_n)
        else $error("fetch strobe missing");
    a_bus_window: assert property (data_oe && host_mode_select |-> !output_data_strobe_n
        || (!input_data_strobe_n && port_select_lines[2:1] == 2'b00)) else $error("bus driven");
    a_port_pc: assert property (host_mode_select && input_data_strobe_n
        && output_data_strobe_n |-> port_select_lines == prog_addr[2:0])
        else $error("port lines not counter bits");
endmodule : deb_bus_ctrl_assertions

bind deb_bus_ctrl deb_bus_ctrl_assertions u_chk (.*);

// [sim/deb_io_model.sv]
// Model of the I/O peripheral on the far side of the data bus.
// Assumes the strobes and port lines of the bus control block.
`timescale 1ns/1ps
module deb_io_model (
    // Bus pins.
    input  wire logic        ref_clk,
    input  wire logic        input_data_strobe_n,
    input  wire logic [2:0]  port_select_lines,
    output logic      [15:0] data_in
);
    initial data_in = 16'h0000;
    // A released bus toggles, so a stale word never passes for a read.
    always @(posedge ref_clk)
        data_in <= !input_data_strobe_n ? {13'h0A50, port_select_lines} : ~data_in;
endmodule : deb_io_model

// [sim/deb_bus_ctrl_tb.sv]
// Self-checking bench of the external bus control block.
// Assumes the peripheral model and the bound checker beside it.
`timescale 1ns/1ps
module deb_bus_ctrl_tb;
    import deb_pkg::*;
    // Stimulus and observed signals.
    logic ref_clk = 0, arst_n = 0, irq_grant = 0, reset_in_n = 1, branch_poll_input = 1;
    logic ext_irq_alt_n = 1, memory_map_select = 1, host_mode_select = 1, coproc_rd_n = 1;
    logic coproc_wr_n = 1, latch_byte_select = 0, wb_ack, cycle_tick, irq_request;
    logic fetch_external, data_oe, divided_clock_out, user_flag_output, serial_out_oe;
    logic program_fetch_strobe_n, input_data_strobe_n, output_data_strobe_n;
    logic [2:0] port_select_lines, port_select_oe;
    logic [ADDR_W-1:0] prog_counter, prog_addr;
    logic [15:0] core_rdata, data_in, data_out, io_d;
    logic [31:0] wb_dat_r, rd;
    deb_wb_req_s wb_req = '0;
    deb_cmd_s cmd = '0;
    int errors = 0, n_compared = 0;
    // The device wins the bus while it drives it.
    assign data_in = data_oe ? data_out : io_d;
    deb_bus_ctrl u_dut (.*);
    deb_io_model u_io (.ref_clk, .input_data_strobe_n, .port_select_lines, .data_in(io_d));
    // Free running 100 MHz clock.
    always #5 ref_clk = ~ref_clk;
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        n_compared++;
        if (s !== e)
        begin
            errors++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    function automatic logic [6:0] pins();
        return {program_fetch_strobe_n, input_data_strobe_n, output_data_strobe_n,
                data_oe, port_select_lines};
    endfunction : pins
    // One classic cycle, held until ack.
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r);
        @(posedge ref_clk);
        wb_req <= '{1'b1, 1'b1, w, a, 4'hF, d};
        @(posedge ref_clk iff wb_ack);
        r = wb_dat_r;
        wb_req <= '0;
    endtask : wb
    // One machine cycle command.
    task automatic mc(input deb_op_e o, input logic [2:0] p, input logic [11:0] t);
        @(posedge ref_clk iff cycle_tick);
        cmd <= '{o, p, t, 16'h5A5A};
        @(posedge ref_clk iff cycle_tick);
        cmd <= '0;
        #1;
    endtask : mc
    task automatic t_io;
        mc(DEB_OP_IN, 3'd6, 12'h000);
        chk("in6", pins(), 32'h0000_0056);
        repeat (3) @(posedge ref_clk);
        #1 chk("rdata", core_rdata, 32'h0000_5286);
        mc(DEB_OP_IN, 3'd1, 12'h000);
        chk("in1", pins(), 32'h0000_0059);
        mc(DEB_OP_OUT, 3'd5, 12'h000);
        chk("out5", {pins(), data_out}, 32'h006D_5A5A);
        mc(DEB_OP_TBLW2, 3'd0, 12'h000);
        chk("table_store_instruction", pins() >> 3, 32'h0000_000D);
    endtask : t_io
    task automatic t_poll;
        branch_poll_input <= 1'b0;
        repeat (8) @(posedge ref_clk);
        mc(DEB_OP_POLL_BRANCH_INSTRUCTION, 3'd0, 12'h700);
        chk("br", prog_counter, 32'h0000_0700);
        repeat (4) @(posedge ref_clk);
        #1 chk("ext", fetch_external, 32'h0000_0001);
        mc(DEB_OP_POLL_BRANCH_INSTRUCTION, 3'd0, 12'h100);
        repeat (4) @(posedge ref_clk);
        #1 chk("onchip", {fetch_external, program_fetch_strobe_n}, 32'h0);
        memory_map_select <= 1'b0;
        branch_poll_input <= 1'b1;
        repeat (12) @(posedge ref_clk);
        #1 chk("allext", fetch_external, 32'h0000_0001);
        mc(DEB_OP_POLL_BRANCH_INSTRUCTION, 3'd0, 12'h700);
        chk("nobr", prog_counter == 12'h700, 32'h0);
        memory_map_select <= 1'b1;
    endtask : t_poll
    task automatic t_irq;
        wb(1'b1, 8'h00, 32'h0000_0406, rd);
        repeat (2) @(posedge ref_clk);
        ext_irq_alt_n <= 1'b0;
        #1 chk("flag", user_flag_output, 32'h0000_0001);
        repeat (8) @(posedge ref_clk);
        ext_irq_alt_n <= 1'b1;
        repeat (8) @(posedge ref_clk);
        #1 chk("pend", irq_request, 32'h0000_0001);
        wb(1'b0, 8'h00, 32'h0, rd);
        chk("ctl", rd, 32'h0000_0407);
        irq_grant <= 1'b1;
        @(posedge ref_clk);
        irq_grant <= 1'b0;
        repeat (2) @(posedge ref_clk);
        #1 chk("grant", irq_request, 32'h0);
        reset_in_n <= 1'b0;
        repeat (20) @(posedge ref_clk);
        #1 chk("rst", {pins() >> 3, serial_out_oe, prog_addr}, 32'h0001_C000);
        reset_in_n <= 1'b1;
        repeat (12) @(posedge ref_clk);
        wb(1'b0, 8'h00, 32'h0, rd);
        chk("keep", rd, 32'h0000_0404);
        wb(1'b0, 8'h10, 32'h0, rd);
        chk("unmap", rd, 32'h0);
    endtask : t_irq
    task automatic t_host;
        wb(1'b1, 8'h08, 32'h0000_BEEF, rd);
        host_mode_select <= 1'b0;
        repeat (12) @(posedge ref_clk);
        coproc_rd_n <= 1'b0;
        repeat (10) @(posedge ref_clk);
        coproc_rd_n <= 1'b1;
        #1 chk("hrd", {data_oe, data_out}, 32'h0001_BEEF);
        repeat (10) @(posedge ref_clk);
        #1 chk("hrel", data_oe, 32'h0);
        coproc_wr_n <= 1'b0;
        repeat (10) @(posedge ref_clk);
        coproc_wr_n <= 1'b1;
        repeat (12) @(posedge ref_clk);
        #1 chk("hport", {port_select_oe, port_select_lines}, 32'h0000_0030);
    endtask : t_host
    task automatic end_of_test;
        if (errors == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : end_of_test
    // Main sequence.
    initial
    begin
        repeat (12) @(posedge ref_clk);
        arst_n <= 1'b1;
        repeat (12) @(posedge ref_clk);
        t_io();
        t_poll();
        t_irq();
        t_host();
        end_of_test();
    end
    // Watchdog against a hang.
    initial
    begin
        repeat (5000) @(posedge ref_clk);
        errors++;
        end_of_test();
    end
endmodule : deb_bus_ctrl_tb
